// file: logic/sccc_pkg.sv
// constants, carriers and helpers for the sync, coast and clamp control registers
// Functional notes
// - clamp polarity bit acts only with external clamp; 0 high, 1 low.
// - coast select 0 takes coast pin, 1 takes vertical sync.
// - coast polarity override 0 uses detected polarity, 1 uses programmed bit.
// - coast polarity bit 0 means active low, 1 active high.
// - low-power seek allowed only while seek override bit is one.
// - sleep bit is active low: 0 powers the chip down.
// - five-bit slicer level in bits 7:3 drives the slicer comparator.
// - per-channel clamp target bits: 0 ground, 1 midscale.
// - separator counts 5 MHz periods up to threshold before toggling output.
// - coast rises the programmed number of lines before vertical sync.
// - coast holds the programmed number of lines after vertical sync.
// - status bit 7 shows horizontal sync present.
// - status bit 6 shows horizontal source: 0 pin, 1 green.
// - status bit 5 shows input horizontal sync polarity, 1 active high.
// - status bit 4 shows vertical sync present.
// - status bit 3 shows vertical source: 0 pin, 1 separator.
// - status bit 2 shows output vertical sync polarity, 1 active high.
// - status bit 1 shows sync present on green.
// - status bit 0 shows coast input polarity, 1 active high.
// - format bit 1 selects 4:2:2 when zero, 4:4:4 when one.
// - without override, horizontal source is chosen automatically and reported.
package sccc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h0F;
  localparam logic [7:0] ADDR_SLICE  = 8'h10;
  localparam logic [7:0] ADDR_SEPTH  = 8'h11;
  localparam logic [7:0] ADDR_PRE    = 8'h12;
  localparam logic [7:0] ADDR_POST   = 8'h13;
  localparam logic [7:0] ADDR_STAT   = 8'h14;
  localparam logic [7:0] ADDR_FMT    = 8'h15;

  // reset values
  localparam logic [7:0] RST_CTRL    = 8'h4E;
  localparam logic [7:0] RST_SLICE   = 8'hB8;
  localparam logic [7:0] RST_SEPTH   = 8'h20;
  localparam logic [7:0] RST_PRE     = 8'h00;
  localparam logic [7:0] RST_POST    = 8'h00;
  localparam logic [7:0] RST_FMT     = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions in the control register
  localparam int CTL_CLAMP_EXT = 7;
  localparam int CTL_CLAMP_POL = 6;
  localparam int CTL_COAST_VS  = 5;
  localparam int CTL_COAST_OVR = 4;
  localparam int CTL_COAST_POL = 3;
  localparam int CTL_SEEK_OK   = 2;
  localparam int CTL_AWAKE     = 1;

  // slicer level and clamp target fields
  localparam int SOG_LVL_HI    = 7;
  localparam int SOG_LVL_LO    = 3;
  localparam int CLAMP_MID_HI  = 2;
  localparam int CLAMP_MID_LO  = 0;

  // status byte fields
  localparam int ST_HS_DET     = 7;
  localparam int ST_HS_SRC     = 6;
  localparam int ST_HS_POL     = 5;
  localparam int ST_VS_DET     = 4;
  localparam int ST_VS_SRC     = 3;
  localparam int ST_VS_POL     = 2;
  localparam int ST_SOG_DET    = 1;
  localparam int ST_COAST_POL  = 0;

  // format register field
  localparam int FMT_444       = 1;

  ////////////////////////////////////////////////////////////////////////////
  // pin vector positions, the first four are watched by activity monitors
  localparam int PIN_HS        = 0;
  localparam int PIN_VS        = 1;
  localparam int PIN_SOG       = 2;
  localparam int PIN_COAST     = 3;
  localparam int PIN_CLAMP     = 4;
  localparam int NUM_MON       = 4;
  localparam int NUM_PINS      = 5;

  ////////////////////////////////////////////////////////////////////////////
  // timing: separator time base derived from the system clock
  localparam int SYS_PERIOD_NS   = 20;
  localparam int SEP_PERIOD_NS   = 200;
  localparam int SEP_TICK_CYCLES = SEP_PERIOD_NS / SYS_PERIOD_NS;
  localparam int TICK_W          = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SEP_TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sccc_reg_req_t;

  typedef struct packed {
    logic       sleep;
    logic       low_power;
    logic [4:0] sog_level;
    logic [2:0] clamp_mid;
    logic       format_444;
  } sccc_ctrl_t;

  typedef struct packed {
    logic pll_coast;
    logic clamp;
    logic hsync;
    logic vsync;
    logic sep_vsync;
  } sccc_sync_t;

  // turn a raw level into an active-high assertion
  function automatic logic sccc_act(input logic level, input logic active_high);
    return active_high ? level : ~level;
  endfunction

endpackage

// file: logic/sccc_sync_monitor.sv
// activity and polarity monitor for one synchronised sync input
`timescale 1ns/1ps
module sccc_sync_monitor #(
  parameter int WIN_LOG2 = 20
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic sig_i,
  output logic      present_o,
  output logic      active_high_o
);

  logic [WIN_LOG2-1:0] win_cnt;
  logic [WIN_LOG2-1:0] high_cnt;
  logic                prev;
  logic                saw_edge;
  wire logic           sig_edge = sig_i ^ prev;
  wire logic           win_end  = &win_cnt;

  // window-based toggle presence and majority-level polarity
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      win_cnt       <= '0;
      high_cnt      <= '0;
      prev          <= 1'b0;
      saw_edge      <= 1'b0;
      present_o     <= 1'b0;
      active_high_o <= 1'b0;
    end else if (ce_i) begin
      prev    <= sig_i;
      win_cnt <= win_cnt + 1'b1;
      if (win_end) begin
        present_o     <= saw_edge | sig_edge;
        // short high time means pulses are high
        active_high_o <= ~high_cnt[WIN_LOG2-1];
        saw_edge      <= 1'b0;
        high_cnt      <= '0;
      end else begin
        saw_edge <= saw_edge | sig_edge;
        high_cnt <= high_cnt + WIN_LOG2'(sig_i);
      end
    end
  end

endmodule

// file: logic/sccc_regs.sv
// sync, coast and clamp control register slice with sync processing
`timescale 1ns/1ps
module sccc_regs
  import sccc_pkg::*;
#(
  parameter int WIN_LOG2 = 20,
  parameter int LINE_W   = 11
) (
  input  wire logic          clk_sys_i,
  input  wire logic          sys_rst_i,
  input  wire logic          ce_i,
  input  wire sccc_reg_req_t reg_req_i,
  output logic [7:0]         reg_rdata_o,
  input  wire logic [NUM_PINS-1:0] pin_i,
  input  wire logic          hs_override_i,
  input  wire logic          hs_select_i,
  input  wire logic          vs_override_i,
  input  wire logic          vs_select_i,
  output sccc_ctrl_t         ctrl_o,
  output sccc_sync_t         sync_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0]          ctrl;
  logic [7:0]          slice;
  logic [7:0]          sep_thr;
  logic [7:0]          pre_lines;
  logic [7:0]          post_lines;
  logic [7:0]          fmt;
  logic [NUM_PINS-1:0] pin_m;
  logic [NUM_PINS-1:0] pin_s;
  logic [NUM_MON-1:0]  mon_pres;
  logic [NUM_MON-1:0]  mon_pol;
  logic [TICK_W-1:0]   tick_cnt;
  logic [7:0]          sep_cnt;
  logic                sep_seen;
  logic                sep_vs;
  logic                hs_prev;
  logic                vs_prev;
  logic [LINE_W-1:0]   line_cnt;
  logic [LINE_W-1:0]   frame_lines;
  logic [7:0]          post_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  wire logic wr_ctrl  = reg_req_i.wr && (reg_req_i.addr == ADDR_CTRL);
  wire logic wr_slice = reg_req_i.wr && (reg_req_i.addr == ADDR_SLICE);
  wire logic wr_septh = reg_req_i.wr && (reg_req_i.addr == ADDR_SEPTH);
  wire logic wr_pre   = reg_req_i.wr && (reg_req_i.addr == ADDR_PRE);
  wire logic wr_post  = reg_req_i.wr && (reg_req_i.addr == ADDR_POST);
  wire logic wr_fmt   = reg_req_i.wr && (reg_req_i.addr == ADDR_FMT);

  // pin synchronisers, second stage only is read by logic
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_m <= '0;
      pin_s <= '0;
    end else if (ce_i) begin
      pin_m <= pin_i;
      pin_s <= pin_m;
    end
  end

  // activity and polarity monitors for hsync, vsync, green sync and coast
  for (genvar g = 0; g < NUM_MON; g++) begin : g_mon
    sccc_sync_monitor #(
      .WIN_LOG2      (WIN_LOG2)
    ) u_mon (
      .clk_sys_i     (clk_sys_i),
      .sys_rst_i     (sys_rst_i),
      .ce_i          (ce_i),
      .sig_i         (pin_s[g]),
      .present_o     (mon_pres[g]),
      .active_high_o (mon_pol[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // horizontal source choice
  wire logic hs_pres  = mon_pres[PIN_HS];
  wire logic sog_pres = mon_pres[PIN_SOG];
  wire logic vs_pres  = mon_pres[PIN_VS];
  wire logic hs_auto  = (hs_pres && sog_pres) ? hs_select_i : (!hs_pres && sog_pres);
  wire logic hs_src   = hs_override_i ? hs_select_i : hs_auto;
  wire logic hs_level = hs_src ? pin_s[PIN_SOG] : pin_s[PIN_HS];
  wire logic hs_pol   = hs_src ? mon_pol[PIN_SOG] : mon_pol[PIN_HS];
  wire logic hs_act   = sccc_act(hs_level, hs_pol);
  wire logic hs_rise  = hs_act && !hs_prev;

  // vertical source choice, separator when the pin is quiet
  wire logic vs_src    = vs_override_i ? vs_select_i : !vs_pres;
  wire logic vs_pin_act = sccc_act(pin_s[PIN_VS], mon_pol[PIN_VS]);
  wire logic vs_used   = vs_src ? sep_vs : vs_pin_act;
  wire logic vs_out_pol = vs_src ? 1'h1 : mon_pol[PIN_VS];
  wire logic vs_rise   = vs_used && !vs_prev;
  wire logic vs_fall   = !vs_used && vs_prev;

  ////////////////////////////////////////////////////////////////////////////
  // coast generation
  wire logic [LINE_W:0] pre_sum = {1'b0, line_cnt} + (LINE_W+1)'(pre_lines);
  wire logic pre_hit  = (frame_lines != '0) && (pre_sum >= {1'b0, frame_lines});
  wire logic coast_vs = vs_used || (post_cnt != 8'h00) || pre_hit;
  wire logic coast_pol = ctrl[CTL_COAST_OVR] ? ctrl[CTL_COAST_POL] : mon_pol[PIN_COAST];
  // coast bit one is active high
  wire logic coast_pin = sccc_act(pin_s[PIN_COAST], coast_pol);
  wire logic pll_coast = ctrl[CTL_COAST_VS] ? coast_vs : coast_pin;

  wire logic clamp_ext = sccc_act(pin_s[PIN_CLAMP], ~ctrl[CTL_CLAMP_POL]);
  wire logic clamp     = ctrl[CTL_CLAMP_EXT] ? clamp_ext : hs_act;

  // seek low power only when allowed and no hsync or green sync seen
  wire logic low_power = ctrl[CTL_SEEK_OK] && !hs_pres && !sog_pres;

  ////////////////////////////////////////////////////////////////////////////
  // status byte assembly
  wire logic [7:0] status = {
    hs_pres,                // hsync present
    hs_src,                 // hsync source in use
    hs_pol,                 // input hsync polarity
    vs_pres,                // vsync present
    vs_src,                 // vsync source in use
    vs_out_pol,             // output vsync polarity
    sog_pres,               // green sync present
    mon_pol[PIN_COAST]      // coast input polarity
  };

  // read mux, unmapped offsets read zero
  wire logic [7:0] rd_mux =
    (reg_req_i.addr == ADDR_CTRL)  ? ctrl       :
    (reg_req_i.addr == ADDR_SLICE) ? slice      :
    (reg_req_i.addr == ADDR_SEPTH) ? sep_thr    :
    (reg_req_i.addr == ADDR_PRE)   ? pre_lines  :
    (reg_req_i.addr == ADDR_POST)  ? post_lines :
    (reg_req_i.addr == ADDR_STAT)  ? status     :
    (reg_req_i.addr == ADDR_FMT)   ? fmt        : RD_UNMAPPED;

  ////////////////////////////////////////////////////////////////////////////
  // writes land on the completing strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl       <= RST_CTRL;
      slice      <= RST_SLICE;
      sep_thr    <= RST_SEPTH;
      pre_lines  <= RST_PRE;
      post_lines <= RST_POST;
      fmt        <= RST_FMT;
    end else if (ce_i) begin
      if (wr_ctrl)  ctrl       <= reg_req_i.wdata;
      if (wr_slice) slice      <= reg_req_i.wdata;
      if (wr_septh) sep_thr    <= reg_req_i.wdata;
      if (wr_pre)   pre_lines  <= reg_req_i.wdata;
      if (wr_post)  post_lines <= reg_req_i.wdata;
      if (wr_fmt)   fmt        <= reg_req_i.wdata;
    end
  end

  // read data captured live on the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= RD_UNMAPPED;
    end else if (ce_i && reg_req_i.rd) begin
      reg_rdata_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // separator counts 5 MHz ticks
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tick_cnt <= '0;
      sep_cnt  <= 8'h00;
      sep_seen <= 1'b0;
      sep_vs   <= 1'b0;
    end else if (ce_i) begin
      tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
      if (tick_cnt == TICK_LAST) begin
        if (hs_act != sep_seen) begin
          sep_seen <= hs_act;
          sep_cnt  <= 8'h00;
        end else if (sep_cnt == sep_thr) begin
          sep_vs <= sep_seen;        // long pulse level wins
        end else begin
          sep_cnt <= sep_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      // matches the idle level of the normalised hsync right after reset
      hs_prev     <= 1'b1;
      vs_prev     <= 1'b0;
      line_cnt    <= '0;
      frame_lines <= '0;
    end else if (ce_i) begin
      hs_prev <= hs_act;
      vs_prev <= vs_used;
      if (vs_rise) begin
        frame_lines <= line_cnt;
        line_cnt    <= '0;
      end else if (hs_rise && !(&line_cnt)) begin
        line_cnt <= line_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      post_cnt <= 8'h00;
    end else if (ce_i) begin
      if (vs_fall) begin
        post_cnt <= post_lines;
      end else if (hs_rise && (post_cnt != 8'h00)) begin
        post_cnt <= post_cnt - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_o <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      ctrl_o.sleep      <= ~ctrl[CTL_AWAKE];
      ctrl_o.low_power  <= low_power;
      ctrl_o.sog_level  <= slice[SOG_LVL_HI:SOG_LVL_LO];
      ctrl_o.clamp_mid  <= slice[CLAMP_MID_HI:CLAMP_MID_LO];
      ctrl_o.format_444 <= fmt[FMT_444];
      sync_o.pll_coast  <= pll_coast;
      sync_o.clamp      <= clamp;
      sync_o.hsync      <= hs_act;
      sync_o.vsync      <= vs_used;
      sync_o.sep_vsync  <= sep_vs;
    end
  end

endmodule

// file: dv/sccc_regs_monitor.sv
// assertion checker for the sync, coast and clamp register slice
`timescale 1ns/1ps
module sccc_regs_monitor
  import sccc_pkg::*;
#(
  parameter int WIN_LOG2 = 20,
  parameter int LINE_W   = 11
) (
  input  wire logic                clk_sys_i,
  input  wire logic                sys_rst_i,
  input  wire logic                ce_i,
  input  wire sccc_reg_req_t       reg_req_i,
  input  wire logic [7:0]          reg_rdata_o,
  input  wire logic [NUM_PINS-1:0] pin_i,
  input  wire logic                hs_override_i,
  input  wire logic                hs_select_i,
  input  wire logic                vs_override_i,
  input  wire logic                vs_select_i,
  input  wire sccc_ctrl_t          ctrl_o,
  input  wire sccc_sync_t          sync_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // write decode seen at the port
  wire        bus_wr = ce_i && reg_req_i.wr;
  wire        ctl_wr = bus_wr && reg_req_i.addr == ADDR_CTRL;
  wire        slc_wr = bus_wr && reg_req_i.addr == ADDR_SLICE;
  wire        fmt_wr = bus_wr && reg_req_i.addr == ADDR_FMT;
  wire        sep_wr = bus_wr && reg_req_i.addr == ADDR_SEPTH;
  logic [7:0] ctl_q;
  logic [2:0] run_q;

  // shadow of the control byte, count of quiet running cycles
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) ctl_q <= RST_CTRL;
    else if (ctl_wr) ctl_q <= reg_req_i.wdata;
    if (sys_rst_i || !ce_i || ctl_wr) run_q <= 3'h0;
    else if (run_q != 3'h7) run_q <= run_q + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_reset_clears: assert property (disable iff (1'b0) sys_rst_i && ce_i
    |=> ctrl_o == '0 && sync_o == '0 && reg_rdata_o == 8'h00) else $error("reset state");
  a_sleep_active_low: assert property (ctl_wr ##1 (ce_i && !bus_wr)
    |=> ctrl_o.sleep == !$past(reg_req_i.wdata[CTL_AWAKE], 2)) else $error("sleep");
  a_seek_blocks_lp: assert property (
    ctl_wr && !reg_req_i.wdata[CTL_SEEK_OK] ##1 (ce_i && !bus_wr) |=> !ctrl_o.low_power)
    else $error("low power");
  a_slicer_level: assert property (slc_wr ##1 (ce_i && !bus_wr)
    |=> ctrl_o.sog_level == $past(reg_req_i.wdata[SOG_LVL_HI:SOG_LVL_LO], 2))
    else $error("slicer level");
  a_clamp_targets: assert property (slc_wr ##1 (ce_i && !bus_wr)
    |=> ctrl_o.clamp_mid == $past(reg_req_i.wdata[CLAMP_MID_HI:CLAMP_MID_LO], 2))
    else $error("clamp targets");
  a_format_sel: assert property (fmt_wr ##1 (ce_i && !bus_wr)
    |=> ctrl_o.format_444 == $past(reg_req_i.wdata[FMT_444], 2)) else $error("format");
  a_sep_readback: assert property (sep_wr ##1 !bus_wr
    ##1 (ce_i && reg_req_i.rd && !bus_wr && reg_req_i.addr == ADDR_SEPTH)
    |=> reg_rdata_o == $past(reg_req_i.wdata, 3)) else $error("threshold readback");
  a_unmapped_zero: assert property (ce_i && reg_req_i.rd
    && (reg_req_i.addr < ADDR_CTRL || reg_req_i.addr > ADDR_FMT)
    |=> reg_rdata_o == RD_UNMAPPED) else $error("unmapped read");
  a_ext_clamp_pol: assert property (run_q >= 3'h4 && ctl_q[CTL_CLAMP_EXT]
    |-> sync_o.clamp == ($past(pin_i[PIN_CLAMP], 3) ^ ctl_q[CTL_CLAMP_POL]))
    else $error("external clamp");
  a_coast_pin_pol: assert property (run_q >= 3'h4 && !ctl_q[CTL_COAST_VS]
    && ctl_q[CTL_COAST_OVR]
    |-> sync_o.pll_coast == ($past(pin_i[PIN_COAST], 3) == ctl_q[CTL_COAST_POL]))
    else $error("coast pin");
endmodule

bind sccc_regs sccc_regs_monitor #(
  .WIN_LOG2 (WIN_LOG2),
  .LINE_W   (LINE_W)
) u_mon (
  .clk_sys_i     (clk_sys_i),
  .sys_rst_i     (sys_rst_i),
  .ce_i          (ce_i),
  .reg_req_i     (reg_req_i),
  .reg_rdata_o   (reg_rdata_o),
  .pin_i         (pin_i),
  .hs_override_i (hs_override_i),
  .hs_select_i   (hs_select_i),
  .vs_override_i (vs_override_i),
  .vs_select_i   (vs_select_i),
  .ctrl_o        (ctrl_o),
  .sync_o        (sync_o)
);

// file: dv/sccc_host_model.sv
// host model issuing single byte register accesses
`timescale 1ns/1ps
module sccc_host_model
  import sccc_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] reg_rdata_i,
  output sccc_reg_req_t   reg_req_o
);
  initial reg_req_o = '0;

  // one write pulse, then address and data turned to garbage
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // one read pulse, data taken the cycle after
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    @(posedge clk_sys_i);
    d = reg_rdata_i;
  endtask

  task automatic fmt_wr(input logic f444);
    wr_reg(ADDR_FMT, 8'hFC | {6'h00, f444, 1'b0});
  endtask
endmodule

// file: dv/test_sccc_regs.sv
// self-checking bench for the sync, coast and clamp register slice
`timescale 1ns/1ps
module test_sccc_regs;
  import sccc_pkg::*;
  logic                clk_sys_i;
  logic                sys_rst_i;
  logic                ce_i;
  logic                hs_ovr;
  logic                hs_sel;
  logic                vs_ovr;
  logic                vs_sel;
  logic                hs_en;
  logic                sog_en;
  logic                vs_en;
  logic                coast_pin;
  logic                clamp_pin;
  logic [15:0]         cyc;
  logic [7:0]          rdata;
  logic [7:0]          rd_v;
  int                  n_fail;
  int                  n_compared;
  sccc_reg_req_t       req;
  sccc_ctrl_t          ctrl;
  sccc_sync_t          sync;
  // short sync pulses made from the cycle count
  wire logic [NUM_PINS-1:0] pins = {clamp_pin, coast_pin, sog_en && cyc[3:0] == 4'h0,
                                    vs_en && cyc[4:0] == 5'h00, hs_en && cyc[3:0] == 4'h0};

  sccc_regs #(
    .WIN_LOG2 (6)
  ) DUT (
    .clk_sys_i     (clk_sys_i),
    .sys_rst_i     (sys_rst_i),
    .ce_i          (ce_i),
    .reg_req_i     (req),
    .reg_rdata_o   (rdata),
    .pin_i         (pins),
    .hs_override_i (hs_ovr),
    .hs_select_i   (hs_sel),
    .vs_override_i (vs_ovr),
    .vs_select_i   (vs_sel),
    .ctrl_o        (ctrl),
    .sync_o        (sync)
  );
  sccc_host_model host (
    .clk_sys_i   (clk_sys_i),
    .reg_rdata_i (rdata),
    .reg_req_o   (req)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd_reg(a, rd_v);
    chk(rd_v, e);
  endtask
  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rchk(ADDR_CTRL, RST_CTRL);
    rchk(ADDR_SLICE, RST_SLICE);
    rchk(ADDR_SEPTH, RST_SEPTH);
    rchk(ADDR_PRE, RST_PRE);
    rchk(ADDR_POST, RST_POST);
    rchk(ADDR_FMT, RST_FMT);
    rchk(8'h0E, RD_UNMAPPED);
    rchk(8'h16, RD_UNMAPPED);
    chk({7'h00, ctrl.sleep}, 8'h00);
    chk({3'h0, ctrl.sog_level}, {3'h0, RST_SLICE[7:3]});
    chk({7'h00, ctrl.format_444}, 8'h01);
  endtask

  task automatic t_write_fields();
    logic [7:0] s0;
    host.wr_reg(ADDR_SLICE, 8'h5D);
    host.wr_reg(ADDR_CTRL, 8'h4C);
    host.fmt_wr(1'b0);
    repeat (2) @(posedge clk_sys_i);
    chk({3'h0, ctrl.sog_level}, 8'h0B);
    chk({5'h00, ctrl.clamp_mid}, 8'h05);
    chk({7'h00, ctrl.sleep}, 8'h01);
    chk({7'h00, ctrl.format_444}, 8'h00);
    rchk(ADDR_FMT, 8'hFC);
    host.wr_reg(ADDR_SEPTH, 8'h40);
    rchk(ADDR_SEPTH, 8'h40);
    host.wr_reg(ADDR_PRE, 8'hFF);
    host.wr_reg(ADDR_POST, 8'h01);
    rchk(ADDR_PRE, 8'hFF);
    rchk(ADDR_POST, 8'h01);
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    host.wr_reg(ADDR_PRE, 8'h12);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    rchk(ADDR_PRE, 8'hFF);
    host.rd_reg(ADDR_STAT, s0);
    host.wr_reg(ADDR_STAT, ~s0);
    rchk(ADDR_STAT, s0);
    host.wr_reg(ADDR_CTRL, 8'h4E);
  endtask

  task automatic t_low_power();
    repeat (200) @(posedge clk_sys_i);
    chk({7'h00, ctrl.low_power}, 8'h01);
    host.wr_reg(ADDR_CTRL, 8'h4A);
    repeat (2) @(posedge clk_sys_i);
    chk({7'h00, ctrl.low_power}, 8'h00);
  endtask

  task automatic t_clamp_coast();
    host.wr_reg(ADDR_CTRL, 8'h92);
    @(posedge clk_sys_i);
    clamp_pin <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk({7'h00, sync.clamp}, 8'h01);
    chk({7'h00, sync.pll_coast}, 8'h01);
    host.wr_reg(ADDR_CTRL, 8'hDA);
    repeat (5) @(posedge clk_sys_i);
    chk({7'h00, sync.clamp}, 8'h00);
    chk({7'h00, sync.pll_coast}, 8'h00);
    coast_pin <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk({7'h00, sync.pll_coast}, 8'h01);
    host.wr_reg(ADDR_CTRL, 8'hFA);
    repeat (5) @(posedge clk_sys_i);
    chk({7'h00, sync.pll_coast}, 8'h00);
    host.wr_reg(ADDR_CTRL, 8'hCA);
    repeat (200) @(posedge clk_sys_i);
    chk({7'h00, sync.pll_coast}, 8'h00);
    chk({5'h00, sync.hsync, sync.vsync, sync.sep_vsync}, 8'h00);
    rchk(ADDR_STAT, 8'h2C);
  endtask

  task automatic t_status();
    hs_en <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    host.rd_reg(ADDR_STAT, rd_v);
    chk(rd_v, 8'hAC);
    sog_en <= 1'b1;
    hs_sel <= 1'b1;
    vs_en <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    host.rd_reg(ADDR_STAT, rd_v);
    chk(rd_v, 8'hF6);
    vs_en <= 1'b0;
    vs_ovr <= 1'b1;
    hs_ovr <= 1'b1;
    hs_sel <= 1'b0;
    repeat (200) @(posedge clk_sys_i);
    host.rd_reg(ADDR_STAT, rd_v);
    chk(rd_v, 8'hA6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // cycle count and hang limit
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 16'h0001;
    if (cyc == 16'h4E20) begin
      n_fail++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    {sys_rst_i, ce_i} = 2'b11;
    {hs_ovr, hs_sel, vs_ovr, vs_sel} = 4'h0;
    {hs_en, sog_en, vs_en, coast_pin, clamp_pin} = 5'h00;
    cyc = 16'h0000;
    n_fail = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset_values();
    t_write_fields();
    t_low_power();
    t_clamp_coast();
    t_status();
    finish_test();
  end
endmodule
